// file: ccd_pkg.sv
// shared constants and types for the instruction execution unit
package ccd_pkg;
    localparam int CLK_MHZ = 250;
    localparam int CYC_CLKS = 4;
    localparam int TICK_W = $clog2(CYC_CLKS);
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int FA_W = 7;
    localparam int K_W = 11;
    localparam int FILE_DEPTH = 128;
    localparam int ADDR_W = 12;
    localparam int OPC_HI = 13;
    localparam int OPC_LO = 11;
    localparam int DEST_BIT = 7;
    localparam int LATCH_W = 5;
    localparam int LATCH_HI = 4;
    localparam int LATCH_LO = 3;
    localparam logic [2:0] OPC_IDLE = 3'h0;
    localparam logic [2:0] OPC_KICK = 3'h1;
    localparam logic [2:0] OPC_CALL = 3'h2;
    localparam logic [2:0] OPC_INV = 3'h3;
    localparam logic [2:0] OPC_REG_CLEAR = 3'h4;
    localparam logic [2:0] OPC_ACCUMULATOR_CLEAR = 3'h5;
    localparam logic [2:0] OPC_DEC = 3'h6;
    localparam logic [2:0] OPC_DSZ = 3'h7;
    localparam logic [ADDR_W-1:0] A_INSTR = 12'h000;
    localparam logic [ADDR_W-1:0] A_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] A_ACC = 12'h008;
    localparam logic [ADDR_W-1:0] A_PC = 12'h00C;
    localparam logic [ADDR_W-1:0] A_LATCH = 12'h010;
    localparam logic [ADDR_W-1:0] A_CTRL = 12'h014;
    localparam logic [2:0] FILE_SEL = 3'h1;
    localparam int FILE_SEL_LO = 9;
    localparam int FILE_IDX_LO = 2;
    localparam int SB_ZERO = 0;
    localparam int SB_EXPIRY = 1;
    localparam int SB_SLEEP = 2;
    localparam int SB_PEND = 3;
    localparam int SB_BUSY = 4;
    localparam int CB_RUN = 0;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic FLAG_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {OP_IDLE, OP_KICK, OP_CALL, OP_INV, OP_REG_CLEAR, OP_ACCUMULATOR_CLEAR, OP_DEC,
        OP_DSZ} ccd_op_t;
    typedef enum logic [1:0] {ST_EXEC, ST_IDLE_CYCLE, ST_CALL2} ccd_state_t;
endpackage

// file: ccd_op_if.sv
// decoded instruction fields and datapath result between core, decoder and alu
`timescale 1ns/1ps
interface ccd_op_if;
    import ccd_pkg::*;
    logic [INSTR_W-1:0] instr;
    ccd_op_t op;
    logic [FA_W-1:0] fileAddr;
    logic destFile;
    logic [K_W-1:0] callTarget;
    logic [7:0] operand;
    logic [7:0] result;
    logic resultZero;
    modport dec (input instr, output op, fileAddr, destFile, callTarget);
    modport alu (input op, operand, output result, resultZero);
endinterface

// file: ccd_decode.sv
// instruction word decoder
`timescale 1ns/1ps
module ccd_decode
    import ccd_pkg::*;
(
    ccd_op_if.dec bus // instruction in, fields out
);
    always_comb
    begin
        bus.fileAddr = bus.instr[FA_W-1:0];
        bus.destFile = bus.instr[DEST_BIT];
        bus.callTarget = bus.instr[K_W-1:0];
        case (bus.instr[OPC_HI:OPC_LO])
            OPC_KICK: bus.op = OP_KICK;
            OPC_CALL: bus.op = OP_CALL;
            OPC_INV: bus.op = OP_INV;
            OPC_REG_CLEAR: bus.op = OP_REG_CLEAR;
            OPC_ACCUMULATOR_CLEAR: bus.op = OP_ACCUMULATOR_CLEAR;
            OPC_DEC: bus.op = OP_DEC;
            OPC_DSZ: bus.op = OP_DSZ;
            default: bus.op = OP_IDLE;
        endcase
    end
endmodule

// file: ccd_alu.sv
// result and zero detect for the register instructions
`timescale 1ns/1ps
module ccd_alu
    import ccd_pkg::*;
(
    ccd_op_if.alu bus // operation and operand in, result out
);
    always_comb
    begin
        case (bus.op)
            OP_INV: bus.result = ~bus.operand;
            OP_DEC: bus.result = bus.operand - 8'h01;
            OP_DSZ: bus.result = bus.operand - 8'h01;
            OP_REG_CLEAR: bus.result = ZERO_BYTE;
            OP_ACCUMULATOR_CLEAR: bus.result = ZERO_BYTE;
            default: bus.result = bus.operand;
        endcase
        bus.resultZero = (bus.result == ZERO_BYTE);
    end
endmodule

// file: ccd_core.sv
// instruction execution unit with register access over axi4-lite
// Functional notes
// - Watchdog kick zeroes watchdog counter and prescaler.
// - Watchdog kick sets expiry and sleep flags.
// - Call pushes program counter plus one.
// - Call loads 11-bit target into low PC.
// - Call fills PC 12:11 from latch 4:3.
// - Call takes two cycles, flags untouched.
// - Destination bit picks accumulator or file register.
// - Invert complements register, updates zero flag.
// - Register clear writes zero, sets zero flag.
// - Accumulator clear writes zero, sets zero flag.
// - Decrement subtracts one, updates zero flag.
// - Decrement-skip subtracts one, flags untouched.
// - Zero result discards next, runs idle cycle.
// - Nonzero result continues without idle cycle.
`timescale 1ns/1ps
module ccd_core
    import ccd_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic rst, // async reset, active high
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic watchdogKick, // pulse: clear watchdog counter and prescaler
    output logic stackPush, // pulse: push stackTop onto return stack
    output logic [PC_W-1:0] stackTop // return address to push
);
    ccd_op_if opBus ();

    ccd_decode uDec (
        .bus(opBus)
    );

    ccd_alu uAlu (
        .bus(opBus)
    );

    logic [TICK_W-1:0] tickCnt_r;
    logic runEn_r;
    logic tick;
    ccd_state_t state_r;
    logic pendValid_r;
    logic [INSTR_W-1:0] pendInstr_r;
    logic [PC_W-1:0] pc_r;
    logic [LATCH_W-1:0] pcHighLatch_r;
    logic [7:0] acc_r;
    logic zeroFlag_r;
    logic expiryFlag_r;
    logic sleepFlag_r;
    logic [7:0] fileMem [0:FILE_DEPTH-1];
    logic execNow;
    logic dropNow;
    logic isRegOp;
    logic writesAcc;
    logic writesFile;
    logic awHeld_r;
    logic wHeld_r;
    logic [ADDR_W-1:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic doWrite;
    logic wrFileHit;
    logic wrMapped;
    logic [FA_W-1:0] wrIdx;
    logic [31:0] wrMerged;
    logic [31:0] rdData;
    logic [1:0] rdResp;
    logic [FA_W-1:0] rdIdx;

    function automatic logic [31:0] mergeStrb(input logic [31:0] oldV, input logic [31:0] newV,
        input logic [3:0] strb);
        logic [31:0] res;
        res = oldV;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = newV[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // instruction-cycle enable; stops while software holds the core off
    assign tick = runEn_r && (tickCnt_r == TICK_W'(CYC_CLKS - 1));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tickCnt_r <= '0;
        else if (!runEn_r || tick)
            tickCnt_r <= '0;
        else
            tickCnt_r <= tickCnt_r + TICK_W'(1);
    end

    assign opBus.instr = pendInstr_r;
    assign opBus.operand = fileMem[opBus.fileAddr];
    assign execNow = tick && (state_r == ST_EXEC) && pendValid_r;
    assign dropNow = tick && (state_r != ST_EXEC);
    assign isRegOp = (opBus.op == OP_INV) || (opBus.op == OP_DEC) || (opBus.op == OP_DSZ);
    assign writesAcc = execNow && ((isRegOp && !opBus.destFile) || opBus.op == OP_ACCUMULATOR_CLEAR);
    assign writesFile = execNow && ((isRegOp && opBus.destFile) || opBus.op == OP_REG_CLEAR);

    // sequencing: call and a taken skip each own a second instruction cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_r <= ST_EXEC;
        else if (execNow)
        begin
            case (opBus.op)
                OP_CALL: state_r <= ST_CALL2;
                OP_DSZ: state_r <= opBus.resultZero ? ST_IDLE_CYCLE : ST_EXEC;
                default: state_r <= ST_EXEC;
            endcase
        end
        else if (dropNow)
            state_r <= ST_EXEC;
    end

    // the word pending during a second cycle is the prefetched one and is thrown away
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pendValid_r <= 1'b0;
            pendInstr_r <= '0;
        end
        else if (doWrite && awAddr_r == A_INSTR && !pendValid_r)
        begin
            pendValid_r <= 1'b1;
            pendInstr_r <= wrMerged[INSTR_W-1:0];
        end
        else if (execNow || dropNow)
            pendValid_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pc_r <= PC_RST;
        else if (execNow && opBus.op == OP_CALL)
            pc_r <= {pcHighLatch_r[LATCH_HI:LATCH_LO], opBus.callTarget};
        else if (execNow)
            pc_r <= pc_r + PC_W'(1);
        else if (dropNow && state_r == ST_IDLE_CYCLE)
            pc_r <= pc_r + PC_W'(1);
        else if (doWrite && awAddr_r == A_PC)
            pc_r <= wrMerged[PC_W-1:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pcHighLatch_r <= '0;
        else if (doWrite && awAddr_r == A_LATCH)
            pcHighLatch_r <= wrMerged[LATCH_W-1:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            runEn_r <= 1'b0;
        else if (doWrite && awAddr_r == A_CTRL)
            runEn_r <= wrMerged[CB_RUN];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stackPush <= 1'b0;
            stackTop <= PC_RST;
        end
        else
        begin
            stackPush <= execNow && opBus.op == OP_CALL;
            if (execNow && opBus.op == OP_CALL)
                stackTop <= pc_r + PC_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            watchdogKick <= 1'b0;
        else
            watchdogKick <= execNow && opBus.op == OP_KICK;
    end

    // an instruction result beats a software write landing in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            acc_r <= ACC_RST;
        else if (writesAcc)
            acc_r <= opBus.result;
        else if (doWrite && awAddr_r == A_ACC)
            acc_r <= wrMerged[7:0];
    end

    always_ff @(posedge clk)
    begin
        if (writesFile)
            fileMem[opBus.fileAddr] <= opBus.result;
        else if (doWrite && wrFileHit)
            fileMem[wrIdx] <= wrMerged[7:0];
    end

    // call and decrement-skip leave every flag alone
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            zeroFlag_r <= 1'b0;
            expiryFlag_r <= FLAG_RST;
            sleepFlag_r <= FLAG_RST;
        end
        else if (execNow && opBus.op == OP_KICK)
        begin
            expiryFlag_r <= 1'b1;
            sleepFlag_r <= 1'b1;
        end
        else if (execNow && (opBus.op == OP_REG_CLEAR || opBus.op == OP_ACCUMULATOR_CLEAR))
            zeroFlag_r <= 1'b1;
        else if (execNow && (opBus.op == OP_INV || opBus.op == OP_DEC))
            zeroFlag_r <= opBus.resultZero;
        else if (doWrite && awAddr_r == A_STATUS && !execNow)
        begin
            zeroFlag_r <= wrMerged[SB_ZERO];
            expiryFlag_r <= wrMerged[SB_EXPIRY];
            sleepFlag_r <= wrMerged[SB_SLEEP];
        end
    end

    // write channel: address and data are taken in either order, answered once both held
    assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign wrFileHit = (awAddr_r[ADDR_W-1:FILE_SEL_LO] == FILE_SEL) && (awAddr_r[1:0] == 2'h0);
    assign wrIdx = awAddr_r[FILE_SEL_LO-1:FILE_IDX_LO];
    assign wrMapped = wrFileHit || awAddr_r == A_INSTR || awAddr_r == A_STATUS
        || awAddr_r == A_ACC || awAddr_r == A_PC || awAddr_r == A_LATCH || awAddr_r == A_CTRL;
    assign wrMerged = mergeStrb(32'h0000_0000, wData_r, wStrb_r);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            awHeld_r <= 1'b0;
            s_axi_awready <= 1'b0;
            awAddr_r <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            else if (doWrite)
                awHeld_r <= 1'b0;
            s_axi_awready <= !(s_axi_awvalid && s_axi_awready) && (!awHeld_r || doWrite);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wHeld_r <= 1'b0;
            s_axi_wready <= 1'b0;
            wData_r <= '0;
            wStrb_r <= '0;
        end
        else
        begin
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            else if (doWrite)
                wHeld_r <= 1'b0;
            s_axi_wready <= !(s_axi_wvalid && s_axi_wready) && (!wHeld_r || doWrite);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read channel: one cycle from address taken to data valid
    assign rdIdx = s_axi_araddr[FILE_SEL_LO-1:FILE_IDX_LO];

    always_comb
    begin
        rdData = 32'h0000_0000;
        rdResp = RESP_OKAY;
        if (s_axi_araddr[ADDR_W-1:FILE_SEL_LO] == FILE_SEL && s_axi_araddr[1:0] == 2'h0)
            rdData = 32'(fileMem[rdIdx]);
        else
        begin
            case (s_axi_araddr)
                A_INSTR: rdData = 32'(pendInstr_r);
                A_STATUS: rdData = 32'({state_r != ST_EXEC, pendValid_r, sleepFlag_r,
                    expiryFlag_r, zeroFlag_r});
                A_ACC: rdData = 32'(acc_r);
                A_PC: rdData = 32'(pc_r);
                A_LATCH: rdData = 32'(pcHighLatch_r);
                A_CTRL: rdData = 32'(runEn_r);
                default: rdResp = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !(s_axi_arvalid && s_axi_arready) && (!s_axi_rvalid || s_axi_rready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdData;
                s_axi_rresp <= rdResp;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_call;
        execNow && opBus.op == OP_CALL;
    endsequence

    sequence s_skipZero;
        execNow && opBus.op == OP_DSZ && opBus.resultZero;
    endsequence

    sequence s_idleThenExec;
        (state_r == ST_IDLE_CYCLE)[*4] ##1 (state_r == ST_EXEC);
    endsequence

    property p_kick;
        execNow && opBus.op == OP_KICK |=> watchdogKick && expiryFlag_r && sleepFlag_r
            && zeroFlag_r == $past(zeroFlag_r) ##1 !watchdogKick;
    endproperty
    a_kick: assert property (p_kick) else $error("watchdog kick effect wrong");

    property p_callPush;
        s_call |=> stackPush && stackTop == $past(pc_r) + PC_W'(1) ##1 !stackPush;
    endproperty
    a_callPush: assert property (p_callPush) else $error("call push wrong");

    property p_callTarget;
        s_call |=> pc_r == {$past(pcHighLatch_r[LATCH_HI:LATCH_LO]), $past(opBus.callTarget)};
    endproperty
    a_callTarget: assert property (p_callTarget) else $error("call target wrong");

    property p_callTwo;
        disable iff (rst || !runEn_r)
        s_call |=> (state_r == ST_CALL2 && zeroFlag_r == $past(zeroFlag_r))[*4]
            ##1 state_r == ST_EXEC;
    endproperty
    a_callTwo: assert property (p_callTwo) else $error("call not two cycles");

    property p_invAcc;
        execNow && opBus.op == OP_INV && !opBus.destFile |=> acc_r == ~$past(opBus.operand)
            && zeroFlag_r == (acc_r == ZERO_BYTE);
    endproperty
    a_invAcc: assert property (p_invAcc) else $error("invert to acc wrong");

    property p_clrAcc;
        execNow && opBus.op == OP_ACCUMULATOR_CLEAR |=> acc_r == ZERO_BYTE && zeroFlag_r;
    endproperty
    a_clrAcc: assert property (p_clrAcc) else $error("accumulator clear wrong");

    property p_clrFile;
        execNow && opBus.op == OP_REG_CLEAR |=> zeroFlag_r && acc_r == $past(acc_r);
    endproperty
    a_clrFile: assert property (p_clrFile) else $error("register clear wrong");

    property p_decAcc;
        execNow && opBus.op == OP_DEC && !opBus.destFile
            |=> acc_r == $past(opBus.operand) - 8'h01 && zeroFlag_r == (acc_r == ZERO_BYTE);
    endproperty
    a_decAcc: assert property (p_decAcc) else $error("decrement wrong");

    property p_skipTaken;
        disable iff (rst || !runEn_r)
        s_skipZero |=> s_idleThenExec ##0 pc_r == $past(pc_r, 5) + PC_W'(2);
    endproperty
    a_skipTaken: assert property (p_skipTaken) else $error("skip idle cycle wrong");

    property p_skipNot;
        execNow && opBus.op == OP_DSZ && !opBus.resultZero
            |=> state_r == ST_EXEC && zeroFlag_r == $past(zeroFlag_r);
    endproperty
    a_skipNot: assert property (p_skipNot) else $error("skip without zero");

    property p_single;
        execNow && opBus.op inside {OP_KICK, OP_INV, OP_REG_CLEAR, OP_ACCUMULATOR_CLEAR, OP_DEC}
            |=> state_r == ST_EXEC;
    endproperty
    a_single: assert property (p_single) else $error("single cycle op stalled");
endmodule

// file: tb_ccd_core.sv
// self-checking bench for the instruction execution unit, driven over axi4-lite
`timescale 1ns/1ps
module tb_ccd_core;
    import ccd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic watchdogKick;
    logic stackPush;
    logic [PC_W-1:0] stackTop;
    logic [PC_W-1:0] pushedTop = '0;
    int kickCount = 0;
    int pushCount = 0;
    int n_fail = 0;
    int n_tests = 0;

    always #2 clk = ~clk;

    ccd_core u_ccd_core (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .watchdogKick,
        .stackPush, .stackTop);

    // counting pulses catches both a missing and a stretched pulse
    always @(posedge clk)
    begin
        if (watchdogKick === 1'b1)
            kickCount <= kickCount + 1;
        if (stackPush === 1'b1)
        begin
            pushCount <= pushCount + 1;
            pushedTop <= stackTop;
        end
    end

    task automatic conclude;
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic awOk;
        logic wOk;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        awOk = 1'b0;
        wOk = 1'b0;
        while (!(awOk && wOk))
        begin
            @(posedge clk);
            if (!awOk && s_axi_awready === 1'b1)
            begin
                awOk = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wOk && s_axi_wready === 1'b1)
            begin
                wOk = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1)
            @(posedge clk);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdRaw(input logic [ADDR_W-1:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge clk);
        while (s_axi_arready !== 1'b1)
            @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge clk);
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
        input logic [1:0] er, input string name);
        logic [31:0] d;
        logic [1:0] r;
        rdRaw(a, d, r);
        chk(name, exp, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask

    function automatic logic [ADDR_W-1:0] fa(input int f);
        return 12'h200 + 12'(f * 4);
    endfunction

    function automatic logic [INSTR_W-1:0] ins(input logic [2:0] op, input logic d,
        input logic [6:0] f);
        return {op, 3'h0, d, f};
    endfunction

    // runs one instruction from a known pc and checks where pc lands
    task automatic exec(input logic [INSTR_W-1:0] i, input logic [PC_W-1:0] pcStart,
        input logic [PC_W-1:0] pcExp);
        logic [31:0] d;
        logic [1:0] r;
        int k;
        wr(A_PC, {19'h0, pcStart}, RESP_OKAY);
        wr(A_INSTR, {18'h0, i}, RESP_OKAY);
        k = 0;
        do
        begin
            rdRaw(A_STATUS, d, r);
            k++;
        end
        while ((d[SB_PEND] !== 1'b0 || d[SB_BUSY] !== 1'b0) && k < 50);
        // a poll that runs out of tries counts as a mismatch here
        chk("settled", 32'h0, 32'(d[SB_BUSY:SB_PEND]));
        // two instruction cycles cover a trailing idle or busy cycle
        repeat (8) @(posedge clk);
        rd(A_PC, {19'h0, pcExp}, RESP_OKAY, "pc");
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(A_STATUS, 32'h6, RESP_OKAY, "status");
        rd(12'h018, 32'h0, RESP_SLVERR, "unmapped");
        wr(12'h018, 32'h1, RESP_SLVERR);
        wr(A_CTRL, 32'h1, RESP_OKAY);
        wr(A_STATUS, 32'h1, RESP_OKAY);
        exec(ins(OPC_KICK, 1'b0, 7'h00), 13'h0100, 13'h0101);
        rd(A_STATUS, 32'h7, RESP_OKAY, "status");
        chk("kicks", 32'h1, 32'(kickCount));
        wr(fa(5), 32'h5A, RESP_OKAY);
        wr(A_STATUS, 32'h1, RESP_OKAY);
        exec(ins(OPC_INV, 1'b1, 7'h05), 13'h0100, 13'h0101);
        rd(fa(5), 32'hA5, RESP_OKAY, "file5");
        rd(A_STATUS, 32'h0, RESP_OKAY, "status");
        wr(fa(6), 32'hFF, RESP_OKAY);
        wr(A_ACC, 32'h33, RESP_OKAY);
        wr(A_STATUS, 32'h0, RESP_OKAY);
        exec(ins(OPC_INV, 1'b0, 7'h06), 13'h0100, 13'h0101);
        rd(A_ACC, 32'h0, RESP_OKAY, "acc");
        rd(fa(6), 32'hFF, RESP_OKAY, "file6");
        rd(A_STATUS, 32'h1, RESP_OKAY, "status");
        wr(fa(127), 32'h77, RESP_OKAY);
        wr(A_STATUS, 32'h0, RESP_OKAY);
        exec(ins(OPC_REG_CLEAR, 1'b1, 7'h7F), 13'h0100, 13'h0101);
        rd(fa(127), 32'h0, RESP_OKAY, "file127");
        rd(A_STATUS, 32'h1, RESP_OKAY, "status");
        wr(A_ACC, 32'h33, RESP_OKAY);
        wr(A_STATUS, 32'h0, RESP_OKAY);
        exec(ins(OPC_ACCUMULATOR_CLEAR, 1'b0, 7'h00), 13'h0100, 13'h0101);
        rd(A_ACC, 32'h0, RESP_OKAY, "acc");
        rd(A_STATUS, 32'h1, RESP_OKAY, "status");
        wr(fa(0), 32'h01, RESP_OKAY);
        wr(A_STATUS, 32'h0, RESP_OKAY);
        exec(ins(OPC_DEC, 1'b1, 7'h00), 13'h0100, 13'h0101);
        rd(fa(0), 32'h0, RESP_OKAY, "file0");
        rd(A_STATUS, 32'h1, RESP_OKAY, "status");
        exec(ins(OPC_DEC, 1'b0, 7'h00), 13'h0100, 13'h0101);
        rd(A_ACC, 32'hFF, RESP_OKAY, "acc");
        rd(fa(0), 32'h0, RESP_OKAY, "file0");
        rd(A_STATUS, 32'h0, RESP_OKAY, "status");
        wr(fa(3), 32'h02, RESP_OKAY);
        wr(A_STATUS, 32'h1, RESP_OKAY);
        exec(ins(OPC_DSZ, 1'b1, 7'h03), 13'h0100, 13'h0101);
        rd(fa(3), 32'h01, RESP_OKAY, "file3");
        rd(A_STATUS, 32'h1, RESP_OKAY, "status");
        wr(A_STATUS, 32'h0, RESP_OKAY);
        exec(ins(OPC_DSZ, 1'b1, 7'h03), 13'h0100, 13'h0102);
        rd(fa(3), 32'h0, RESP_OKAY, "file3");
        rd(A_STATUS, 32'h0, RESP_OKAY, "status");
        wr(fa(4), 32'h01, RESP_OKAY);
        wr(A_ACC, 32'h55, RESP_OKAY);
        exec(ins(OPC_DSZ, 1'b0, 7'h04), 13'h0200, 13'h0202);
        rd(A_ACC, 32'h0, RESP_OKAY, "acc");
        rd(fa(4), 32'h01, RESP_OKAY, "file4");
        // an undecoded opcode only advances the pc
        exec(ins(OPC_IDLE, 1'b1, 7'h04), 13'h0300, 13'h0301);
        rd(fa(4), 32'h01, RESP_OKAY, "file4");
        rd(A_ACC, 32'h0, RESP_OKAY, "acc");
        wr(A_LATCH, 32'h18, RESP_OKAY);
        wr(A_STATUS, 32'h5, RESP_OKAY);
        exec({OPC_CALL, 11'h456}, 13'h0123, 13'h1C56);
        chk("pushTop", 32'h0124, {19'h0, pushedTop});
        chk("pushes", 32'h1, 32'(pushCount));
        rd(A_STATUS, 32'h5, RESP_OKAY, "status");
        // low latch bits must not leak into the upper pc
        wr(A_LATCH, 32'h07, RESP_OKAY);
        exec({OPC_CALL, 11'h7FF}, 13'h1FFF, 13'h07FF);
        chk("pushTop", 32'h0000, {19'h0, pushedTop});
        chk("pushes", 32'h2, 32'(pushCount));
        chk("kicks", 32'h1, 32'(kickCount));
        conclude();
    end
endmodule
